// [design/sfr_conflict_pkg.sv]
// Constants for the special function register event/write-back conflict bank
// Operation
// - Second-cycle write-back overrides same-cycle event update
// - External RAM and port accesses never conflict
// - Suppressed timer overflow gives no interrupt flag
// - Level external interrupt always seen and pollable
// - Edge external interrupt may be lost
// - Timer control bit polling loses only the polled overflow flag; a byte write-back loses both
// - Affected flags in timer, serial, converter registers
// - Receive buffer load lost during write-back
// - Running timer count increments lost on write-back
// - Decode the conflicting two-cycle instructions
package sfr_conflict_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8d;

  // Timer control fields
  localparam int BIT_TIMER1_OVERFLOW = 7;
  localparam int BIT_TIMER1_RUN = 6;
  localparam int BIT_TIMER0_OVERFLOW = 5;
  localparam int BIT_TIMER0_RUN = 4;
  localparam int BIT_EXT_IRQ1_FLAG = 3;
  localparam int BIT_EXT_IRQ1_EDGE_MODE = 2;
  localparam int BIT_EXT_IRQ0_FLAG = 1;
  localparam int BIT_EXT_IRQ0_EDGE_MODE = 0;

  // Serial control fields
  localparam int BIT_RECEIVED_NINTH = 2;
  localparam int BIT_SERIAL_TRANSMIT = 1;
  localparam int BIT_SERIAL_RECEIVE = 0;

  // Converter control fields
  localparam int BIT_CONVERTER_BUSY = 4;

  // Reset values
  localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RESET_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] RESET_SERIAL_BUFFER = 8'h00;
  localparam logic [7:0] RESET_CONVERTER_CONTROL = 8'h00;
  localparam logic [15:0] RESET_TIMER_COUNT = 16'h0000;

  // Two-cycle read-modify-write opcodes whose write-back collides
  localparam logic [7:0] OP_LOGICAL_AND_DIRECT_IMM = 8'h53;
  localparam logic [7:0] OP_LOGICAL_OR_DIRECT_IMM = 8'h43;
  localparam logic [7:0] OP_LOGICAL_XOR_DIRECT_IMM = 8'h63;
  localparam logic [7:0] OP_BIT_MOVE_FROM_CARRY = 8'h92;
  localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO = 8'hd5;
  localparam logic [7:0] OP_JUMP_BIT_THEN_CLEAR = 8'h10;

  localparam logic [15:0] TIMER_COUNT_MAX = 16'hffff;
endpackage

// [design/timer_counter.sv]
// Sixteen-bit timer count pair with byte write-back
`timescale 1ns/10ps
module timer_counter (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire logic [7:0] i_wdata,
  output logic [15:0] o_count,
  output logic o_overflow,
  output logic o_inc_lost
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic inc;

  always_comb begin
    inc = i_run && i_tick;
    count_nxt = count_r;
    if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
    // A byte written back in the same cycle replaces that byte of the incremented value
    if (i_wr_low) begin
      count_nxt[7:0] = i_wdata;
    end
    if (i_wr_high) begin
      count_nxt[15:8] = i_wdata;
    end
    o_inc_lost = inc && (i_wr_low || i_wr_high);
    o_overflow = inc && !(i_wr_low || i_wr_high) &&
                 (count_r == sfr_conflict_pkg::TIMER_COUNT_MAX);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_r <= sfr_conflict_pkg::RESET_TIMER_COUNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign o_count = count_r;
endmodule

// [design/sfr_rmw_event_conflict.sv]
// Special function register bank where CPU write-back meets hardware events
`timescale 1ns/10ps
module sfr_rmw_event_conflict (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_ext_space,
  input wire logic [7:0] i_addr,
  input wire logic i_bit_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_opcode,
  input wire logic i_second_cycle,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_timer_tick,
  input wire logic i_tx_done,
  input wire logic i_rx_load,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_ninth,
  input wire logic i_conv_start,
  input wire logic i_conv_done,
  input wire logic i_ext_irq0_n,
  input wire logic i_ext_irq1_n,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_timer_control,
  output logic [7:0] o_serial_control,
  output logic [7:0] o_converter_control,
  output logic o_event_lost
);
  logic [7:0] timer_control_r;
  logic [7:0] timer_control_nxt;
  logic [7:0] serial_control_r;
  logic [7:0] serial_control_nxt;
  logic [7:0] serial_buffer_r;
  logic [7:0] serial_buffer_nxt;
  logic [7:0] converter_control_r;
  logic [7:0] converter_control_nxt;
  logic [1:0] irq_pin_prev_r;
  logic [1:0] irq_pin_prev_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic event_lost_r;
  logic event_lost_nxt;

  logic sfr_wr;
  logic rmw_conflict;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [1:0] irq_pin_level;
  logic [1:0] irq_edge_mode;
  logic [1:0] irq_fell;
  logic [1:0] timer_run;
  logic [1:0] timer_ovf;
  logic [1:0] timer_inc_lost;
  logic [1:0] wr_low;
  logic [1:0] wr_high;
  logic [15:0] timer_count [2];
  logic [7:0] tc_set;
  logic [7:0] tc_force;
  logic [7:0] tc_force_val;
  logic [7:0] sc_set;
  logic [7:0] sc_val;
  logic [7:0] cc_set;
  logic [7:0] cc_clr;
  logic [3:0] lost;
  logic lost_tc;
  logic lost_sc;
  logic lost_sb;
  logic lost_cc;
  logic wr_timer_control;
  logic wr_serial_control;
  logic wr_serial_buffer;
  logic wr_converter_control;
  logic [7:0] timer_wdata [2];

  // Accesses to external data memory or ports never touch this bank
  assign sfr_wr = i_wr && !i_ext_space;

  // One strobe per bank register keeps each merge below independent
  assign wr_timer_control = sfr_wr && (i_addr == sfr_conflict_pkg::ADDR_TIMER_CONTROL);
  assign wr_serial_control = sfr_wr && (i_addr == sfr_conflict_pkg::ADDR_SERIAL_CONTROL);
  assign wr_serial_buffer = sfr_wr && (i_addr == sfr_conflict_pkg::ADDR_SERIAL_BUFFER);
  assign wr_converter_control = sfr_wr && (i_addr == sfr_conflict_pkg::ADDR_CONVERTER_CONTROL);

  always_comb begin
    rmw_conflict = 1'b0;
    if (i_second_cycle) begin
      case (i_opcode)
        sfr_conflict_pkg::OP_LOGICAL_AND_DIRECT_IMM: rmw_conflict = 1'b1;
        sfr_conflict_pkg::OP_LOGICAL_OR_DIRECT_IMM: rmw_conflict = 1'b1;
        sfr_conflict_pkg::OP_LOGICAL_XOR_DIRECT_IMM: rmw_conflict = 1'b1;
        sfr_conflict_pkg::OP_BIT_MOVE_FROM_CARRY: rmw_conflict = 1'b1;
        sfr_conflict_pkg::OP_DECREMENT_JUMP_NONZERO: rmw_conflict = 1'b1;
        sfr_conflict_pkg::OP_JUMP_BIT_THEN_CLEAR: rmw_conflict = 1'b1;
        default: rmw_conflict = 1'b0;
      endcase
    end
  end

  // A bit instruction writes back only the selected bit; others stay live
  always_comb begin
    wmask = 8'hff;
    wval = i_wdata;
    if (i_bit_op) begin
      wmask = 8'h01 << i_bit_sel;
      wval = {8{i_wdata[0]}};
    end
  end

  always_comb begin
    irq_pin_level = {~i_ext_irq1_n, ~i_ext_irq0_n};
    irq_edge_mode = {timer_control_r[sfr_conflict_pkg::BIT_EXT_IRQ1_EDGE_MODE],
                     timer_control_r[sfr_conflict_pkg::BIT_EXT_IRQ0_EDGE_MODE]};
    timer_run = {timer_control_r[sfr_conflict_pkg::BIT_TIMER1_RUN],
                 timer_control_r[sfr_conflict_pkg::BIT_TIMER0_RUN]};
    irq_pin_prev_nxt = {i_ext_irq1_n, i_ext_irq0_n};
    irq_fell = irq_pin_prev_r & ~irq_pin_prev_nxt;
  end

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_timer
      always_comb begin
        wr_low[t] = sfr_wr && (i_addr == (t == 0 ? sfr_conflict_pkg::ADDR_TIMER0_LOW :
                                                    sfr_conflict_pkg::ADDR_TIMER1_LOW));
        wr_high[t] = sfr_wr && (i_addr == (t == 0 ? sfr_conflict_pkg::ADDR_TIMER0_HIGH :
                                                     sfr_conflict_pkg::ADDR_TIMER1_HIGH));
        // A bit write replaces only its selected bit of the live count byte
        timer_wdata[t] = (wval & wmask) |
                         ((wr_low[t] ? timer_count[t][7:0] : timer_count[t][15:8]) & ~wmask);
      end
      timer_counter u_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(timer_run[t]),
        .i_tick(i_timer_tick),
        .i_wr_low(wr_low[t]),
        .i_wr_high(wr_high[t]),
        .i_wdata(timer_wdata[t]),
        .o_count(timer_count[t]),
        .o_overflow(timer_ovf[t]),
        .o_inc_lost(timer_inc_lost[t])
      );
    end
  endgenerate

  // Hardware-side updates of each register before any CPU write-back
  always_comb begin
    tc_set = 8'h00;
    tc_force = 8'h00;
    tc_force_val = 8'h00;
    tc_set[sfr_conflict_pkg::BIT_TIMER0_OVERFLOW] = timer_ovf[0];
    tc_set[sfr_conflict_pkg::BIT_TIMER1_OVERFLOW] = timer_ovf[1];
    // Edge mode latches a falling pin; level mode mirrors the pin itself
    tc_set[sfr_conflict_pkg::BIT_EXT_IRQ0_FLAG] = irq_edge_mode[0] && irq_fell[0];
    tc_set[sfr_conflict_pkg::BIT_EXT_IRQ1_FLAG] = irq_edge_mode[1] && irq_fell[1];
    tc_force[sfr_conflict_pkg::BIT_EXT_IRQ0_FLAG] = !irq_edge_mode[0];
    tc_force[sfr_conflict_pkg::BIT_EXT_IRQ1_FLAG] = !irq_edge_mode[1];
    tc_force_val[sfr_conflict_pkg::BIT_EXT_IRQ0_FLAG] = irq_pin_level[0];
    tc_force_val[sfr_conflict_pkg::BIT_EXT_IRQ1_FLAG] = irq_pin_level[1];

    sc_set = 8'h00;
    sc_val = 8'h00;
    sc_set[sfr_conflict_pkg::BIT_SERIAL_TRANSMIT] = i_tx_done;
    sc_val[sfr_conflict_pkg::BIT_SERIAL_TRANSMIT] = 1'b1;
    sc_set[sfr_conflict_pkg::BIT_SERIAL_RECEIVE] = i_rx_load;
    sc_val[sfr_conflict_pkg::BIT_SERIAL_RECEIVE] = 1'b1;
    sc_set[sfr_conflict_pkg::BIT_RECEIVED_NINTH] = i_rx_load;
    sc_val[sfr_conflict_pkg::BIT_RECEIVED_NINTH] = i_rx_ninth;

    cc_set = 8'h00;
    cc_clr = 8'h00;
    cc_set[sfr_conflict_pkg::BIT_CONVERTER_BUSY] = i_conv_start;
    cc_clr[sfr_conflict_pkg::BIT_CONVERTER_BUSY] = i_conv_done && !i_conv_start;
  end

  // Merge: a conflicting write-back beats the event on written bits only;
  // any other write lets a same-cycle hardware set win over a clear
  always_comb begin
    timer_control_nxt = timer_control_r | tc_set;
    lost_tc = 1'b0;
    if (wr_timer_control) begin
      if (rmw_conflict) begin
        timer_control_nxt = (timer_control_nxt & ~wmask) | (wval & wmask);
        lost_tc = |(tc_set & wmask);
      end else begin
        timer_control_nxt = (timer_control_r & ~wmask) | (wval & wmask) | tc_set;
      end
    end
    // The level-mode flag follows the pin every cycle, so no write hides it
    timer_control_nxt = (timer_control_nxt & ~tc_force) | (tc_force_val & tc_force);
  end

  always_comb begin
    serial_control_nxt = (serial_control_r & ~sc_set) | (sc_val & sc_set);
    lost_sc = 1'b0;
    if (wr_serial_control) begin
      if (rmw_conflict) begin
        serial_control_nxt = (serial_control_nxt & ~wmask) | (wval & wmask);
        lost_sc = |(sc_set & wmask);
      end else begin
        serial_control_nxt = (((serial_control_r & ~wmask) | (wval & wmask)) & ~sc_set)
                             | (sc_val & sc_set);
      end
    end
  end

  // A plain write to the buffer yields to a byte arriving in the same cycle
  always_comb begin
    serial_buffer_nxt = i_rx_load ? i_rx_byte : serial_buffer_r;
    lost_sb = 1'b0;
    if (wr_serial_buffer) begin
      if (rmw_conflict) begin
        serial_buffer_nxt = (serial_buffer_nxt & ~wmask) | (wval & wmask);
        lost_sb = i_rx_load;
      end else if (!i_rx_load) begin
        serial_buffer_nxt = (serial_buffer_r & ~wmask) | (wval & wmask);
      end
    end
  end

  always_comb begin
    converter_control_nxt = (converter_control_r | cc_set) & ~cc_clr;
    lost_cc = 1'b0;
    if (wr_converter_control) begin
      if (rmw_conflict) begin
        converter_control_nxt = (converter_control_nxt & ~wmask) | (wval & wmask);
        lost_cc = |((cc_set | cc_clr) & wmask);
      end else begin
        converter_control_nxt = (((converter_control_r & ~wmask) | (wval & wmask))
                                 | cc_set) & ~cc_clr;
      end
    end
  end

  assign lost = {lost_cc, lost_sb, lost_sc, lost_tc};
  assign event_lost_nxt = (|lost) || (|timer_inc_lost);

  always_comb begin
    case (i_rd_addr)
      sfr_conflict_pkg::ADDR_TIMER_CONTROL: rd_data_nxt = timer_control_r;
      sfr_conflict_pkg::ADDR_SERIAL_CONTROL: rd_data_nxt = serial_control_r;
      sfr_conflict_pkg::ADDR_SERIAL_BUFFER: rd_data_nxt = serial_buffer_r;
      sfr_conflict_pkg::ADDR_CONVERTER_CONTROL: rd_data_nxt = converter_control_r;
      sfr_conflict_pkg::ADDR_TIMER0_LOW: rd_data_nxt = timer_count[0][7:0];
      sfr_conflict_pkg::ADDR_TIMER1_LOW: rd_data_nxt = timer_count[1][7:0];
      sfr_conflict_pkg::ADDR_TIMER0_HIGH: rd_data_nxt = timer_count[0][15:8];
      sfr_conflict_pkg::ADDR_TIMER1_HIGH: rd_data_nxt = timer_count[1][15:8];
      default: rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timer_control_r <= sfr_conflict_pkg::RESET_TIMER_CONTROL;
    end else begin
      timer_control_r <= timer_control_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      serial_control_r <= sfr_conflict_pkg::RESET_SERIAL_CONTROL;
    end else begin
      serial_control_r <= serial_control_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      serial_buffer_r <= sfr_conflict_pkg::RESET_SERIAL_BUFFER;
    end else begin
      serial_buffer_r <= serial_buffer_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      converter_control_r <= sfr_conflict_pkg::RESET_CONVERTER_CONTROL;
    end else begin
      converter_control_r <= converter_control_nxt;
    end
  end

  // Pin history starts at the idle high level, so release shows no false edge
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_pin_prev_r <= 2'h3;
    end else begin
      irq_pin_prev_r <= irq_pin_prev_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      event_lost_r <= 1'b0;
    end else begin
      event_lost_r <= event_lost_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_timer_control = timer_control_r;
  assign o_serial_control = serial_control_r;
  assign o_converter_control = converter_control_r;
  assign o_event_lost = event_lost_r;
endmodule

// [testbench/sfr_rmw_event_conflict_properties.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
module sfr_rmw_event_conflict_properties (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_ext_space,
  input wire logic [7:0] i_addr,
  input wire logic i_bit_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_opcode,
  input wire logic i_second_cycle,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_tx_done,
  input wire logic i_rx_load,
  input wire logic i_conv_start,
  input wire logic i_ext_irq0_n,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_timer_control,
  input wire logic [7:0] o_serial_control,
  input wire logic [7:0] o_converter_control,
  input wire logic o_event_lost
);
  logic op_hit;
  logic rmw_wb;
  assign op_hit = i_opcode inside {sfr_conflict_pkg::OP_LOGICAL_AND_DIRECT_IMM,
    sfr_conflict_pkg::OP_LOGICAL_OR_DIRECT_IMM, sfr_conflict_pkg::OP_LOGICAL_XOR_DIRECT_IMM,
    sfr_conflict_pkg::OP_BIT_MOVE_FROM_CARRY, sfr_conflict_pkg::OP_DECREMENT_JUMP_NONZERO,
    sfr_conflict_pkg::OP_JUMP_BIT_THEN_CLEAR};
  assign rmw_wb = i_wr && !i_ext_space && i_second_cycle && op_hit;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_rmw_on(a);
    rmw_wb && !i_bit_op && i_addr == a;
  endsequence
  // Buffer read follows the colliding write-back with no write between
  sequence s_buf_read;
    s_rmw_on(8'h99) ##0 i_rx_load ##1 (i_rd_addr == 8'h99 && !i_wr && !i_rx_load);
  endsequence
  tx_flag_lost_a: assert property (s_rmw_on(8'h98) ##0 (i_tx_done && !i_wdata[1]) |=>
    !o_serial_control[1] && o_event_lost) else $error("transmit flag survived write-back");
  plain_set_wins_a: assert property (i_wr && !i_ext_space && !(i_second_cycle && op_hit) &&
    i_addr == 8'h98 && i_tx_done |=> o_serial_control[1]) else $error("plain write beat set");
  ext_ignored_a: assert property (i_wr && i_ext_space && !i_tx_done && !i_rx_load |=>
    $stable(o_serial_control)) else $error("external access changed serial control");
  level_irq_seen_a: assert property ((!i_ext_irq0_n && !o_timer_control[0]) [*2] |=>
    o_timer_control[1]) else $error("level interrupt flag not visible");
  overflow_lost_a: assert property (s_rmw_on(8'h88) ##0 (!i_wdata[5] && !i_wdata[7]) |=>
    !o_timer_control[5] && !o_timer_control[7]) else $error("overflow flag survived");
  buffer_lost_a: assert property (s_buf_read |=> o_rd_data == $past(i_wdata, 2))
    else $error("receive buffer load beat write-back");
  busy_lost_a: assert property (s_rmw_on(8'hd8) ##0 (i_conv_start && !i_wdata[4]) |=>
    !o_converter_control[4] && o_event_lost) else $error("busy bit survived write-back");
  other_bit_a: assert property (rmw_wb && i_bit_op && i_addr == 8'h98 && i_bit_sel == 3'h1 &&
    i_rx_load |=> o_serial_control[0]) else $error("other bit event was lost");
endmodule
bind sfr_rmw_event_conflict sfr_rmw_event_conflict_properties checker_i (.*);

// [testbench/cpu_core_model.sv]
// Behavioural CPU core issuing two-cycle read-modify-write bus cycles
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rd_data,
  output logic o_wr = 1'b0,
  output logic o_ext_space = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic o_bit_op = 1'b0,
  output logic [2:0] o_bit_sel = 3'h0,
  output logic [7:0] o_wdata = 8'h00,
  output logic [7:0] o_opcode = 8'h00,
  output logic o_second_cycle = 1'b0,
  output logic [7:0] o_rd_addr = 8'h00
);
  task automatic exec(input logic [7:0] op, adr, dat, input logic bo, input logic [2:0] sel,
      input logic sc, ex);
    @(posedge i_clock);
    #2 o_rd_addr = adr;
    @(posedge i_clock);
    #2 o_wr = 1'b1;
    o_ext_space = ex;
    o_addr = adr;
    o_bit_op = bo;
    o_bit_sel = sel;
    o_wdata = dat;
    o_opcode = op;
    o_second_cycle = sc;
    @(posedge i_clock);
    // Released lines show the inverse so a stale value cannot pass for a live one
    #2 o_wr = 1'b0;
    o_second_cycle = 1'b0;
    o_addr = ~adr;
    o_wdata = ~dat;
    o_opcode = ~op;
  endtask
  task automatic read(input logic [7:0] adr, output logic [7:0] d);
    o_rd_addr = adr;
    @(posedge i_clock);
    #2 d = i_rd_data;
  endtask
endmodule

// [testbench/sfr_rmw_event_conflict_tb.sv]
// Self-checking bench for the register bank write-back conflict
`timescale 1ns/10ps
module sfr_rmw_event_conflict_tb;
  logic i_clock, i_rst, i_wr, i_ext_space, i_bit_op, i_second_cycle, o_event_lost;
  logic [7:0] i_addr, i_wdata, i_opcode, i_rd_addr, i_rx_byte, o_rd_data, rd_val;
  logic [2:0] i_bit_sel;
  logic i_timer_tick, i_tx_done, i_rx_load, i_rx_ninth, i_conv_start, i_conv_done;
  logic i_ext_irq0_n, i_ext_irq1_n;
  logic [7:0] o_timer_control, o_serial_control, o_converter_control;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] ops [8] = '{8'h53, 8'h43, 8'h63, 8'h92, 8'hd5, 8'h10, 8'h52, 8'hc2};
  sfr_rmw_event_conflict dut (.*);
  cpu_core_model cpu (.i_clock(i_clock), .i_rd_data(o_rd_data), .o_wr(i_wr),
    .o_ext_space(i_ext_space), .o_addr(i_addr), .o_bit_op(i_bit_op), .o_bit_sel(i_bit_sel),
    .o_wdata(i_wdata), .o_opcode(i_opcode), .o_second_cycle(i_second_cycle),
    .o_rd_addr(i_rd_addr));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic peek(input logic [7:0] adr, input logic [7:0] exp, input string name);
    cpu.read(adr, rd_val);
    chk(name, exp, rd_val);
  endtask
  task automatic put(input logic [7:0] adr, input logic [7:0] dat);
    cpu.exec(8'hf5, adr, dat, 1'b0, 3'h0, 1'b0, 1'b0);
  endtask
  // Event pulses land exactly in the write-back cycle of the instruction
  task automatic collide(input logic [7:0] op, adr, dat, input logic bo,
      input logic [2:0] sel, input logic sc, ex, input logic [3:0] ev);
    fork
      cpu.exec(op, adr, dat, bo, sel, sc, ex);
      begin
        repeat (2) @(posedge i_clock);
        #2 {i_timer_tick, i_tx_done, i_rx_load, i_conv_start} = ev;
        @(posedge i_clock);
        #2 {i_timer_tick, i_tx_done, i_rx_load, i_conv_start} = 4'h0;
      end
    join
  endtask
  task automatic t_reset;
    chk("timer_control", sfr_conflict_pkg::RESET_TIMER_CONTROL, o_timer_control);
    chk("serial_control", sfr_conflict_pkg::RESET_SERIAL_CONTROL, o_serial_control);
    chk("converter_control", sfr_conflict_pkg::RESET_CONVERTER_CONTROL, o_converter_control);
    peek(8'h99, sfr_conflict_pkg::RESET_SERIAL_BUFFER, "serial_buffer");
    peek(8'h42, 8'h00, "unmapped");
  endtask
  task automatic t_opcodes;
    logic bo;
    logic hw;
    for (int i = 0; i < 8; i++) begin
      bo = (ops[i] == 8'h92) || (ops[i] == 8'h10) || (ops[i] == 8'hc2);
      hw = (i > 5);
      collide(ops[i], 8'h98, 8'h00, bo, 3'h1, 1'b1, 1'b0, 4'h6);
      chk("serial_control", {5'h00, hw | bo, hw, hw | bo}, o_serial_control);
      chk("event_lost", {7'h00, !hw}, {7'h00, o_event_lost});
      put(8'h98, 8'h00);
    end
  endtask
  task automatic t_ext;
    collide(8'h53, 8'h98, 8'h00, 1'b0, 3'h0, 1'b1, 1'b1, 4'h4);
    chk("serial_control", 8'h02, o_serial_control);
    collide(8'h53, 8'h98, 8'h00, 1'b0, 3'h0, 1'b1, 1'b1, 4'h0);
    chk("serial_control", 8'h02, o_serial_control);
    put(8'h98, 8'h00);
  endtask
  task automatic t_timer;
    put(8'h88, 8'h10);
    put(8'h8a, 8'hff);
    put(8'h8c, 8'hff);
    collide(8'h43, 8'h88, 8'h10, 1'b0, 3'h0, 1'b1, 1'b0, 4'h8);
    chk("timer_control", 8'h10, o_timer_control);
    peek(8'h8c, 8'h00, "timer0_count_high");
    collide(8'h53, 8'h8a, 8'h05, 1'b0, 3'h0, 1'b1, 1'b0, 4'h8);
    peek(8'h8a, 8'h05, "timer0_count_low");
    i_timer_tick = 1'b1;
    @(posedge i_clock);
    #2 i_timer_tick = 1'b0;
    peek(8'h8a, 8'h06, "timer0_count_low");
  endtask
  task automatic t_irq;
    i_ext_irq0_n = 1'b0;
    repeat (2) @(posedge i_clock);
    collide(8'h53, 8'h88, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0, 4'h0);
    chk("timer_control", 8'h02, o_timer_control);
    i_ext_irq0_n = 1'b1;
    put(8'h88, 8'h01);
    i_ext_irq0_n = 1'b0;
    repeat (3) @(posedge i_clock);
    #2 i_ext_irq0_n = 1'b1;
    repeat (2) @(posedge i_clock);
    #2 chk("timer_control", 8'h03, o_timer_control);
    cpu.exec(8'hc2, 8'h88, 8'h00, 1'b1, 3'h1, 1'b0, 1'b0);
    chk("timer_control", 8'h01, o_timer_control);
  endtask
  task automatic t_buffer;
    collide(8'h63, 8'h99, 8'ha5, 1'b0, 3'h0, 1'b1, 1'b0, 4'h2);
    peek(8'h99, 8'ha5, "serial_buffer");
    chk("serial_control", 8'h05, o_serial_control);
  endtask
  task automatic t_conv;
    collide(8'h53, 8'hd8, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0, 4'h1);
    chk("converter_control", 8'h00, o_converter_control);
    collide(8'hf5, 8'hd8, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 4'h1);
    chk("converter_control", 8'h10, o_converter_control);
    i_conv_done = 1'b1;
    @(posedge i_clock);
    #2 i_conv_done = 1'b0;
    chk("converter_control", 8'h00, o_converter_control);
  endtask
  initial begin
    i_rst = 1'b1;
    {i_timer_tick, i_tx_done, i_rx_load, i_conv_start, i_conv_done} = 5'h00;
    {i_ext_irq0_n, i_ext_irq1_n, i_rx_ninth} = 3'h7;
    i_rx_byte = 8'h3c;
    repeat (16) @(posedge i_clock);
    #2 i_rst = 1'b0;
    t_reset;
    t_opcodes;
    t_ext;
    t_timer;
    t_irq;
    t_buffer;
    t_conv;
    wrap_up;
  end
  // The whole sequence needs about 120 cycles; this is far beyond that
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
